// ==== design/supervisor_defs.svh ====
// timing constants for the reset supervisor
// assumes a 10 MHz clock; all counts derived from times in their own unit
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
`define CLK_PERIOD_NS 100
`define CLK_PER_MS (1000000 / `CLK_PERIOD_NS)
`define WD_SHORT_MS 150
`define WD_MID_MS 600
`define WD_LONG_MS 1200
`define RST_ACTIVE_MS 610
`define PB_DEBOUNCE_MS 4
`define SUPPLY_DETECT_US 5
`define WD_SHORT_CYC (`WD_SHORT_MS * `CLK_PER_MS)
`define WD_MID_CYC (`WD_MID_MS * `CLK_PER_MS)
`define WD_LONG_CYC (`WD_LONG_MS * `CLK_PER_MS)
`define RST_ACTIVE_CYC (`RST_ACTIVE_MS * `CLK_PER_MS)
`define PB_DEBOUNCE_CYC (`PB_DEBOUNCE_MS * `CLK_PER_MS)
`define CNT_W 24
`endif

// ==== design/supervisor_pkg.sv ====
// types for the reset supervisor
// no surroundings assumed
package supervisor_pkg;
    typedef enum logic [1:0] {
        PERIOD_SHORT = 2'h0,
        PERIOD_MID = 2'h1,
        PERIOD_LONG = 2'h2
    } period_sel_type;
    typedef struct packed {
        logic reset_n;
        logic reset_hi;
    } reset_out_type;
endpackage

// ==== design/supervisor_reset_watchdog.sv ====
// reset supervisor: supply monitor, debounced manual reset, watchdog, stretched reset
// assumes all inputs synchronous to clk; supply comparator result arrives as a level
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"
module supervisor_reset_watchdog #(
    parameter int unsigned WD_SHORT = `WD_SHORT_CYC,
    parameter int unsigned WD_MID = `WD_MID_CYC,
    parameter int unsigned WD_LONG = `WD_LONG_CYC,
    parameter int unsigned RST_ACTIVE = `RST_ACTIVE_CYC,
    parameter int unsigned PB_DEBOUNCE = `PB_DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic supply_low,
    input wire logic threshold_select,
    input wire supervisor_pkg::period_sel_type watchdog_period_select,
    input wire logic manual_reset_n,
    input wire logic watchdog_strobe_n,
    output logic threshold_select_out,
    output supervisor_pkg::reset_out_type reset_out
);
    import supervisor_pkg::*;

    typedef enum logic [1:0] {
        RUN,
        HOLD,
        STRETCH
    } state_type;

    state_type state_r;
    logic [`CNT_W-1:0] wd_cnt_r;
    logic [`CNT_W-1:0] hold_cnt_r;
    logic [`CNT_W-1:0] pb_cnt_r;
    logic strobe_prev_r;
    logic pb_active_r;
    logic wd_fire_r;
    logic [`CNT_W-1:0] wd_limit;
    logic strobe_fall;
    logic cause;

    // threshold select is passed to the analog comparator, which reports supply_low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            threshold_select_out <= 1'b0;
        end else begin
            threshold_select_out <= threshold_select;
        end
    end

    always_comb begin
        unique case (watchdog_period_select)
            PERIOD_MID: wd_limit = `CNT_W'(WD_MID);
            PERIOD_LONG: wd_limit = `CNT_W'(WD_LONG);
            default: wd_limit = `CNT_W'(WD_SHORT);
        endcase
    end

    assign strobe_fall = strobe_prev_r && !watchdog_strobe_n;
    assign cause = supply_low || pb_active_r || wd_fire_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_prev_r <= 1'b1;
        end else begin
            strobe_prev_r <= watchdog_strobe_n;
        end
    end

    // debounce: 4 ms of steady low, so sub-1 ms glitches never qualify
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pb_cnt_r <= '0;
            pb_active_r <= 1'b0;
        end else if (manual_reset_n) begin
            pb_cnt_r <= '0;
            pb_active_r <= 1'b0;
        end else if (pb_cnt_r < `CNT_W'(PB_DEBOUNCE - 1)) begin
            pb_cnt_r <= pb_cnt_r + `CNT_W'(1);
        end else begin
            pb_active_r <= 1'b1;
        end
    end

    // watchdog counts only while outputs released
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_cnt_r <= '0;
            wd_fire_r <= 1'b0;
        end else if (state_r != RUN) begin
            wd_cnt_r <= '0;
            wd_fire_r <= 1'b0;
        end else if (strobe_fall) begin
            wd_cnt_r <= '0;
        end else if (wd_cnt_r >= wd_limit - `CNT_W'(1)) begin
            wd_fire_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + `CNT_W'(1);
        end
    end

    // power-up starts in hold so the system sees a full reset period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= HOLD;
            hold_cnt_r <= '0;
        end else begin
            unique case (state_r)
                RUN: begin
                    if (cause) begin
                        state_r <= HOLD;
                    end
                end
                HOLD: begin
                    hold_cnt_r <= '0;
                    if (!supply_low && !pb_active_r) begin
                        state_r <= STRETCH;
                    end
                end
                STRETCH: begin
                    if (supply_low || pb_active_r) begin
                        state_r <= HOLD;
                    end else if (hold_cnt_r >= `CNT_W'(RST_ACTIVE - 1)) begin
                        state_r <= RUN;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + `CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // outputs taken from one flop pair so they cannot disagree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reset_out <= '{reset_n: 1'b0, reset_hi: 1'b1};
        end else begin
            reset_out.reset_n <= !(cause || state_r != RUN);
            reset_out.reset_hi <= cause || state_r != RUN;
        end
    end

    complement_a: assert property (@(posedge clk) disable iff (reset)
        reset_out.reset_n == !reset_out.reset_hi) else $error("reset outputs not complementary");
    supply_assert_a: assert property (@(posedge clk) disable iff (reset)
        supply_low |=> reset_out.reset_hi) else $error("supply low did not assert reset");
    short_pulse_a: assert property (@(posedge clk) disable iff (reset)
        $fell(manual_reset_n) |-> !pb_active_r) else $error("manual reset qualified too soon");
    // a counter check instead of a long repetition: debounce spans tens of thousands of cycles
    pb_count_a: assert property (@(posedge clk) disable iff (reset)
        (!manual_reset_n && pb_cnt_r == `CNT_W'(PB_DEBOUNCE - 1)) |=> pb_active_r)
        else $error("manual reset not qualified in time");

    pb_glitch_a: assert property (@(posedge clk) disable iff (reset)
        $rose(pb_active_r) |-> pb_cnt_r == `CNT_W'(PB_DEBOUNCE - 1))
        else $error("manual reset qualified before full debounce");

    pb_clear_a: assert property (@(posedge clk) disable iff (reset)
        manual_reset_n |=> (!pb_active_r && pb_cnt_r == '0))
        else $error("manual release did not clear debounce");

    // stretch and output checks
    hold_block_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == HOLD && (supply_low || pb_active_r)) |=> state_r == HOLD)
        else $error("hold left while a cause stands");

    supply_hold_a: assert property (@(posedge clk) disable iff (reset)
        supply_low |=> state_r == HOLD)
        else $error("supply low did not force hold");

    stretch_start_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_r == STRETCH) |-> hold_cnt_r == '0)
        else $error("stretch began with stale count");

    stretch_len_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == STRETCH && hold_cnt_r < `CNT_W'(RST_ACTIVE - 1) && !supply_low && !pb_active_r)
        |=> state_r == STRETCH)
        else $error("stretch ended before active time");

    out_hold_a: assert property (@(posedge clk) disable iff (reset)
        (state_r != RUN) |=> reset_out.reset_hi)
        else $error("outputs released while not running");

    run_release_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == RUN && !cause) |=> !reset_out.reset_hi)
        else $error("outputs stuck asserted while running");

    // watchdog and pass-through checks
    wd_count_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == RUN && !strobe_fall && wd_cnt_r < wd_limit - `CNT_W'(1))
        |=> wd_cnt_r == $past(wd_cnt_r) + `CNT_W'(1))
        else $error("watchdog count did not advance");

    thresh_pass_a: assert property (@(posedge clk) disable iff (reset)
        threshold_select |=> threshold_select_out)
        else $error("threshold select not passed on");

    stretch_hold_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_r == STRETCH) |=> reset_out.reset_hi) else $error("stretch released early");
    wd_fire_a: assert property (@(posedge clk) disable iff (reset)
        wd_fire_r |=> ##1 reset_out.reset_hi) else $error("watchdog timeout lost");
    strobe_kick_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == RUN && strobe_fall && !cause) |=> wd_cnt_r == '0) else $error("strobe did not restart");
    wd_restart_a: assert property (@(posedge clk) disable iff (reset)
        (state_r != RUN) |=> !wd_fire_r) else $error("watchdog not restarted by reset");
    release_c: cover property (@(posedge clk) disable iff (reset) $fell(reset_out.reset_hi));
    kick_c: cover property (@(posedge clk) disable iff (reset) state_r == RUN && strobe_fall);
    stretch_c: cover property (@(posedge clk) disable iff (reset) $rose(state_r == STRETCH));
    wd_c: cover property (@(posedge clk) disable iff (reset) $rose(wd_fire_r));
    pb_c: cover property (@(posedge clk) disable iff (reset) $rose(pb_active_r));
endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
// supervised processor: strobes the watchdog while it runs and kicks are enabled
// assumes the same clk as the supervisor; it stays silent while held in reset
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int KICK = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic kick_en,
    input wire supervisor_pkg::reset_out_type reset_out,
    output logic watchdog_strobe_n = 1'h1
);
    import supervisor_pkg::*;
    int cnt_r;
    // a held processor cannot strobe, so kicks wait for release
    always @(posedge clk) begin
        if (reset || !kick_en || !reset_out.reset_n) begin
            cnt_r <= 0;
            watchdog_strobe_n <= 1'h1;
        end else begin
            cnt_r <= (cnt_r == KICK - 1) ? 0 : cnt_r + 1;
            watchdog_strobe_n <= (cnt_r >= KICK - 2) ? 1'h0 : 1'h1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// bench for the reset supervisor with a strobing host model
// assumes scaled-down counts so every timing fits a short run
`timescale 1ns/1ps
`default_nettype none
module tb;
    import supervisor_pkg::*;
    localparam int WS = 50, WM = 100, WL = 200, RA = 40, PD = 10;
    logic clk = 0, reset = 1, supply_low = 0, threshold_select = 0, manual_reset_n = 1, kick_en = 0;
    period_sel_type watchdog_period_select = PERIOD_SHORT;
    logic watchdog_strobe_n, threshold_select_out;
    reset_out_type reset_out;
    int n_errors = 0, checks_done = 0;
    always #50 clk = ~clk;
    supervisor_reset_watchdog #(.WD_SHORT(WS), .WD_MID(WM), .WD_LONG(WL), .RST_ACTIVE(RA), .PB_DEBOUNCE(PD))
        supervisor_reset_watchdog_i (.clk(clk), .reset(reset), .supply_low(supply_low),
        .threshold_select(threshold_select), .watchdog_period_select(watchdog_period_select),
        .manual_reset_n(manual_reset_n), .watchdog_strobe_n(watchdog_strobe_n),
        .threshold_select_out(threshold_select_out), .reset_out(reset_out));
    host_model host_model_i (.clk(clk), .reset(reset), .kick_en(kick_en), .reset_out(reset_out),
        .watchdog_strobe_n(watchdog_strobe_n));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    // outputs hold lvl for n cycles, always as complements
    task automatic hold(input logic lvl, input int n);
        repeat (n) begin
            tick(1);
            check("reset_hi", lvl, reset_out.reset_hi);
            check("reset_n", ~lvl, reset_out.reset_n);
        end
    endtask
    // bounded wait, so a stuck output fails instead of hanging
    task automatic reach(input logic lvl, input int n);
        for (int i = 0; i < n && reset_out.reset_hi !== lvl; i++) tick(1);
        check("reset_hi reached", lvl, reset_out.reset_hi);
    endtask
    task automatic supply_dip();
        threshold_select = 1;
        supply_low = 1;
        tick(2);
        check("reset_hi", 1, reset_out.reset_hi);
        check("threshold_select_out", 1, threshold_select_out);
        supply_low = 0;
        hold(1, RA - 5);
        reach(0, 15);
    endtask
    task automatic manual();
        manual_reset_n = 0;
        tick(PD - 3);
        manual_reset_n = 1;
        hold(0, RA);
        manual_reset_n = 0;
        reach(1, PD + 4);
        hold(1, 20);
        manual_reset_n = 1;
        hold(1, RA - 5);
        reach(0, 15);
    endtask
    task automatic kicked();
        kick_en = 1;
        hold(0, 4 * WS);
        kick_en = 0;
    endtask
    task automatic watchdog(input period_sel_type sel, input int lim);
        watchdog_period_select = sel;
        supply_low = 1;
        tick(1);
        supply_low = 0;
        reach(0, RA + 15);
        hold(0, lim - 5);
        reach(1, 12);
        hold(1, RA - 5);
        reach(0, 15);
    endtask
    task automatic results();
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(10);
        reset = 0;
        check("threshold_select_out", 0, threshold_select_out);
        hold(1, RA - 5);
        reach(0, 15);
        // host keeps strobing so a watchdog timeout cannot mask the manual checks
        kick_en = 1;
        supply_dip();
        manual();
        kicked();
        watchdog(PERIOD_SHORT, WS);
        watchdog(PERIOD_MID, WM);
        watchdog(PERIOD_LONG, WL);
        watchdog(period_sel_type'(2'h3), WS);
        results();
    end
    // whole run needs well under 2000 cycles
    initial begin
        #(100 * 6000);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
